// *** logic/aar_pkg.sv ***
package aar_pkg;
  localparam int CLK_HZ   = 10_000_000;
  localparam int N_ALARM  = 4;
  // Long press threshold for acknowledge and reset
  localparam int HOLD_MS  = 2000;
  localparam int HOLD_CYC = (CLK_HZ / 1000) * HOLD_MS;
  // Key inactivity before a view closes
  localparam int IDLE_S   = 30;
  localparam int IDLE_CYC = CLK_HZ * IDLE_S;
  // Half periods of the two blink rates
  localparam int FAST_MS  = 125;
  localparam int FAST_CYC = (CLK_HZ / 1000) * FAST_MS;
  localparam int SLOW_MS  = 500;
  localparam int SLOW_CYC = (CLK_HZ / 1000) * SLOW_MS;
  // Key positions in the key vector
  localparam int N_KEY    = 7;
  localparam int K_CLEAR  = 0;
  localparam int K_OK     = 1;
  localparam int K_ESC    = 2;
  localparam int K_DOWN   = 3;
  localparam int K_UP     = 4;
  localparam int K_INFO   = 5;
  localparam int K_METER  = 6;
  typedef enum logic [2:0] {
    M_NORM, M_TEXT, M_METER, M_MAXQ, M_MINQ, M_CNTQ
  } aar_mode_t;
endpackage

// *** logic/aar_blink.sv ***
`timescale 1ns/1ps
module aar_blink #(
  parameter int FAST_CYC = aar_pkg::FAST_CYC,
  parameter int SLOW_CYC = aar_pkg::SLOW_CYC
) (
  input  wire logic clock,
  input  wire logic rst,
  output logic      fast,
  output logic      slow
);
  typedef struct packed {
    logic [31:0] fcnt;
    logic [31:0] scnt;
    logic        f;
    logic        s;
  } aar_blink_t;
  aar_blink_t q, d;

  always_comb begin
    d = q;
    d.fcnt = q.fcnt + 32'h0000_0001;
    d.scnt = q.scnt + 32'h0000_0001;
    if (q.fcnt >= 32'(FAST_CYC - 1)) begin // [R17]
      d.fcnt = '0;
      d.f = ~q.f;
    end
    if (q.scnt >= 32'(SLOW_CYC - 1)) begin // [R17]
      d.scnt = '0;
      d.s = ~q.s;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign fast = q.f;
  assign slow = q.s;
endmodule

// *** logic/aar_hold.sv ***
`timescale 1ns/1ps
module aar_hold #(
  parameter int HOLD_CYC = aar_pkg::HOLD_CYC
) (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic held,
  output logic      fire
);
  typedef struct packed {
    logic [31:0] cnt;
    logic        fired;
    logic        pulse;
  } aar_hold_t;
  aar_hold_t q, d;

  always_comb begin
    d = q;
    d.pulse = 1'b0;
    if (!held) begin
      d.cnt = '0;
      d.fired = 1'b0;
    end else if (!q.fired) begin
      d.cnt = q.cnt + 32'h0000_0001;
      // Fires once per press, strictly past the threshold
      if (q.cnt >= 32'(HOLD_CYC)) begin // [R18]
        d.fired = 1'b1;
        d.pulse = 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign fire = q.pulse;
endmodule

// *** logic/aar_panel.sv ***
`timescale 1ns/1ps
// How it works
// R1: LED dark if inactive, steady if acknowledged, fast if unacknowledged, slow if gone.
// R2: Without acknowledge-required flag, LEDs never flash; lit follows alarm state.
// R3: Long clear press acknowledges the shown alarm; fast becomes steady, slow dark.
// R4: With alarm reset configured, acknowledging also pulses that alarm's withdraw output.
// R5: LEDs only for configured logic functions; others stay dark.
// R6: Entering text view with no functions gives an error pulse and stays out.
// R7: Text list holds up to four entries, only the configured functions.
// R8: Shown entry selects active or inactive text by the alarm's present state.
// R9: Text view opens on the highest priority entry.
// R10: Text view closes after 30 s without a key; each key restarts the timer.
// R11: Meter view opens from any mode and closes after 30 s without a key; here it opens only from normal and text view.
// R12: Meter clear only when the reset right is granted; else ignored.
// R13: Reset procedures start only on a long clear press over that quantity.
// R14: Min/max: maximum prompt OK/down/ESC, then minimum prompt OK or abort.
// R15: Meter reset prompt flashes; OK clears the meter, ESC ends without clearing.
// R16: Change protection blocks every reset procedure.
// R17: Fast and slow blink use two fixed periods, fast clearly shorter.
// R18: Long press counted continuously, fires once per press past the threshold.
module aar_panel #(
  parameter int N_ALARM  = aar_pkg::N_ALARM,
  parameter int HOLD_CYC = aar_pkg::HOLD_CYC,
  parameter int IDLE_CYC = aar_pkg::IDLE_CYC,
  parameter int FAST_CYC = aar_pkg::FAST_CYC,
  parameter int SLOW_CYC = aar_pkg::SLOW_CYC
) (
  input  wire logic               clock,
  input  wire logic               rst,
  input  wire logic [N_ALARM-1:0] alarm_active,
  input  wire logic [N_ALARM-1:0] alarm_fn_cfg,
  input  wire logic               ack_required,
  input  wire logic               alarm_reset_cfg,
  input  wire logic               meter_reset_right,
  input  wire logic               change_protect,
  input  wire logic               disp_minmax,
  input  wire logic               disp_counter,
  input  wire logic [6:0]         key_pins,
  output logic      [N_ALARM-1:0] led_on,
  output logic      [N_ALARM-1:0] alarm_withdraw,
  output logic                    text_view,
  output logic      [1:0]         text_index,
  output logic                    text_active_sel,
  output logic                    text_error,
  output logic                    meter_view,
  output logic                    max_flash,
  output logic                    min_flash,
  output logic                    prompt_flash,
  output logic                    clear_max,
  output logic                    clear_min,
  output logic                    clear_meter,
  output logic                    clear_counter
);
  localparam int NK = aar_pkg::N_KEY;

  typedef struct packed {
    aar_pkg::aar_mode_t mode;
    logic [NK-1:0]      ks1;
    logic [NK-1:0]      ks2;
    logic [NK-1:0]      ks3;
    logic [31:0]        idle;
    logic [N_ALARM-1:0] prev;
    logic [N_ALARM-1:0] unack;
    logic [1:0]         idx;
    logic               tact;
    logic               from_meter;
    logic [N_ALARM-1:0] withdraw;
    logic               err;
    logic               cmax;
    logic               cmin;
    logic               cmtr;
    logic               ccnt;
  } aar_state_t;
  aar_state_t q, d;

  logic               fast;
  logic               slow;
  logic               hold_fire;
  logic [NK-1:0]      kr;
  logic               any_key;
  logic [N_ALARM-1:0] shown;
  logic [N_ALARM-1:0] ack_hit;
  logic [N_ALARM-1:0] rise;
  logic [1:0]         first_idx;
  logic [1:0]         up_idx;
  logic [1:0]         dn_idx;
  logic               may_reset;

  aar_blink #(
    .FAST_CYC (FAST_CYC),
    .SLOW_CYC (SLOW_CYC)
  ) u_blink (
    .clock (clock),
    .rst   (rst),
    .fast  (fast),
    .slow  (slow)
  );

  aar_hold #(
    .HOLD_CYC (HOLD_CYC)
  ) u_hold (
    .clock (clock),
    .rst   (rst),
    .held  (q.ks2[aar_pkg::K_CLEAR]),
    .fire  (hold_fire)
  );

  // Key edges only from the second sync stage onward
  assign kr      = q.ks2 & ~q.ks3;
  assign any_key = |kr;
  assign rise    = alarm_active & ~q.prev & alarm_fn_cfg;
  assign may_reset = !change_protect; // [R16]

  // Index walk over configured entries only
  always_comb begin
    logic [1:0] j;
    first_idx = 2'h0;
    up_idx    = q.idx;
    dn_idx    = q.idx;
    j         = 2'h0;
    for (int i = N_ALARM - 1; i >= 0; i--) begin
      if (alarm_fn_cfg[i]) begin
        first_idx = 2'(i);
      end
    end
    // Lowest index is the highest priority; active ones first
    for (int i = N_ALARM - 1; i >= 0; i--) begin
      if (alarm_fn_cfg[i] && alarm_active[i]) begin // [R9]
        first_idx = 2'(i);
      end
    end
    for (int i = 3; i >= 1; i--) begin
      j = q.idx + 2'(i);
      if (alarm_fn_cfg[j]) begin // [R7]
        dn_idx = j;
      end
      j = q.idx - 2'(i);
      if (alarm_fn_cfg[j]) begin // [R7]
        up_idx = j;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < N_ALARM; g++) begin : g_ch
      assign shown[g]   = (q.mode == aar_pkg::M_TEXT) && (q.idx == 2'(g));
      assign ack_hit[g] = shown[g] && hold_fire && alarm_fn_cfg[g]; // [R3]
      always_comb begin
        if (!alarm_fn_cfg[g]) begin
          led_on[g] = 1'b0; // [R5]
        end else if (!ack_required) begin
          led_on[g] = alarm_active[g]; // [R2]
        end else if (alarm_active[g]) begin
          led_on[g] = q.unack[g] ? fast : 1'b1; // [R1]
        end else begin
          led_on[g] = q.unack[g] ? slow : 1'b0; // [R1]
        end
      end
    end
  endgenerate

  always_comb begin
    d = q;
    d.ks1  = key_pins;
    d.ks2  = q.ks1;
    d.ks3  = q.ks2;
    d.prev = alarm_active;
    d.withdraw = '0;
    d.err  = 1'b0;
    d.cmax = 1'b0;
    d.cmin = 1'b0;
    d.cmtr = 1'b0;
    d.ccnt = 1'b0;
    // Event arriving with its acknowledge keeps the flag set
    d.unack = ((q.unack & ~ack_hit) | rise) & {N_ALARM{ack_required}}; // [R3] [R2]
    if (alarm_reset_cfg) begin
      d.withdraw = ack_hit; // [R4]
    end
    d.idle = (any_key || q.mode == aar_pkg::M_NORM) ? '0 : q.idle + 32'h0000_0001; // [R10]
    case (q.mode)
      aar_pkg::M_NORM: begin
        if (kr[aar_pkg::K_METER]) begin
          d.mode = aar_pkg::M_METER; // [R11]
        end else if (kr[aar_pkg::K_INFO]) begin
          if (alarm_fn_cfg == '0) begin
            d.err = 1'b1; // [R6]
          end else begin
            d.mode = aar_pkg::M_TEXT;
            d.idx  = first_idx; // [R9]
          end
        end else if (hold_fire && may_reset && disp_minmax) begin
          d.mode = aar_pkg::M_MAXQ; // [R13]
        end else if (hold_fire && may_reset && disp_counter) begin
          d.mode = aar_pkg::M_CNTQ; // [R13]
          d.from_meter = 1'b0;
        end
      end
      aar_pkg::M_TEXT: begin
        if (kr[aar_pkg::K_ESC] || q.idle >= 32'(IDLE_CYC - 1)) begin
          d.mode = aar_pkg::M_NORM; // [R10]
        end else if (kr[aar_pkg::K_METER]) begin
          d.mode = aar_pkg::M_METER; // [R11]
        end else if (kr[aar_pkg::K_DOWN]) begin
          d.idx = dn_idx; // [R7]
        end else if (kr[aar_pkg::K_UP]) begin
          d.idx = up_idx; // [R7]
        end
      end
      aar_pkg::M_METER: begin
        if (kr[aar_pkg::K_ESC] || q.idle >= 32'(IDLE_CYC - 1)) begin
          d.mode = aar_pkg::M_NORM; // [R11]
        end else if (hold_fire && may_reset && meter_reset_right) begin
          d.mode = aar_pkg::M_CNTQ; // [R12] [R13]
          d.from_meter = 1'b1;
        end
      end
      aar_pkg::M_MAXQ: begin
        if (kr[aar_pkg::K_OK]) begin
          d.cmax = may_reset; // [R14] [R16]
          d.mode = aar_pkg::M_MINQ;
        end else if (kr[aar_pkg::K_DOWN]) begin
          d.mode = aar_pkg::M_MINQ; // [R14]
        end else if (kr[aar_pkg::K_ESC]) begin
          d.mode = aar_pkg::M_NORM; // [R14]
        end
      end
      aar_pkg::M_MINQ: begin
        if (kr[aar_pkg::K_OK]) begin
          d.cmin = may_reset; // [R14] [R16]
          d.mode = aar_pkg::M_NORM;
        end else if (any_key) begin
          d.mode = aar_pkg::M_NORM; // [R14]
        end
      end
      aar_pkg::M_CNTQ: begin
        if (kr[aar_pkg::K_OK]) begin
          d.cmtr = q.from_meter && may_reset && meter_reset_right; // [R15] [R12]
          d.ccnt = !q.from_meter && may_reset; // [R16]
          d.mode = q.from_meter ? aar_pkg::M_METER : aar_pkg::M_NORM;
        end else if (kr[aar_pkg::K_ESC]) begin
          d.mode = q.from_meter ? aar_pkg::M_METER : aar_pkg::M_NORM; // [R15]
        end
      end
      default: begin
        d.mode = aar_pkg::M_NORM;
      end
    endcase
    d.tact = alarm_active[d.idx]; // [R8]
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign alarm_withdraw  = q.withdraw;
  assign text_view       = (q.mode == aar_pkg::M_TEXT);
  assign text_index      = q.idx;
  assign text_active_sel = q.tact;
  assign text_error      = q.err;
  assign meter_view      = (q.mode == aar_pkg::M_METER);
  assign max_flash       = (q.mode == aar_pkg::M_MAXQ);
  assign min_flash       = (q.mode == aar_pkg::M_MINQ);
  assign prompt_flash    = (q.mode == aar_pkg::M_MAXQ) || (q.mode == aar_pkg::M_MINQ)
                           || (q.mode == aar_pkg::M_CNTQ);
  assign clear_max       = q.cmax;
  assign clear_min       = q.cmin;
  assign clear_meter     = q.cmtr;
  assign clear_counter   = q.ccnt;

  a_led_dark_unconfigured: assert property ( // [R5]
    @(posedge clock) disable iff (rst) (led_on & ~alarm_fn_cfg) == '0
  ) else $error("LED lit for unconfigured alarm");

  a_led_no_flash: assert property ( // [R2]
    @(posedge clock) disable iff (rst)
    !ack_required |-> led_on == (alarm_active & alarm_fn_cfg)
  ) else $error("LED flashes without acknowledge required");

  a_led_fast_flash: assert property ( // [R1]
    @(posedge clock) disable iff (rst)
    ack_required |->
      ((led_on ^ {N_ALARM{fast}}) & alarm_fn_cfg & alarm_active & q.unack) == '0
  ) else $error("Unacknowledged active alarm not fast flashing");

  a_led_slow_flash: assert property ( // [R1]
    @(posedge clock) disable iff (rst)
    ack_required |->
      ((led_on ^ {N_ALARM{slow}}) & alarm_fn_cfg & ~alarm_active & q.unack) == '0
  ) else $error("Unacknowledged past alarm not slow flashing");

  a_prompt_needs_hold: assert property ( // [R13]
    @(posedge clock) disable iff (rst)
    (!prompt_flash && !hold_fire) |=> !prompt_flash
  ) else $error("Reset prompt opened without a long press");

  a_ack_clears_flag: assert property ( // [R3]
    @(posedge clock) disable iff (rst)
    (hold_fire && q.mode == aar_pkg::M_TEXT && alarm_fn_cfg[q.idx] && !rise[q.idx])
    |=> !q.unack[$past(q.idx)]
  ) else $error("Acknowledge did not clear the shown alarm");

  a_withdraw_on_ack: assert property ( // [R4]
    @(posedge clock) disable iff (rst)
    (alarm_reset_cfg && |ack_hit) |=> alarm_withdraw == $past(ack_hit)
  ) else $error("Withdraw missing after acknowledge");

  a_error_no_view: assert property ( // [R6]
    @(posedge clock) disable iff (rst)
    (q.mode == aar_pkg::M_NORM && kr[aar_pkg::K_INFO] && !kr[aar_pkg::K_METER]
     && alarm_fn_cfg == '0) |=> text_error && !text_view
  ) else $error("Empty alarm list did not raise error");

  a_text_timeout: assert property ( // [R10]
    @(posedge clock) disable iff (rst)
    (text_view && q.idle >= 32'(IDLE_CYC - 1)) |=> !text_view
  ) else $error("Text view outlived the idle time");

  a_meter_timeout: assert property ( // [R11]
    @(posedge clock) disable iff (rst)
    (meter_view && !any_key && q.idle >= 32'(IDLE_CYC - 1)) |=> !meter_view
  ) else $error("Meter view outlived the idle time");

  a_meter_right: assert property ( // [R12]
    @(posedge clock) disable iff (rst)
    !$past(meter_reset_right) |-> !clear_meter
  ) else $error("Meter cleared without reset right");

  a_minmax_order: assert property ( // [R14]
    @(posedge clock) disable iff (rst)
    (max_flash && kr[aar_pkg::K_OK]) |=> min_flash ##0 (clear_max || $past(change_protect))
  ) else $error("Maximum confirm did not advance");

  a_protect_blocks: assert property ( // [R16]
    @(posedge clock) disable iff (rst)
    $past(change_protect) |-> !(clear_max || clear_min || clear_meter || clear_counter)
  ) else $error("Reset carried out under protection");

  a_text_first_prio: assert property ( // [R9]
    @(posedge clock) disable iff (rst)
    (q.mode == aar_pkg::M_NORM && kr[aar_pkg::K_INFO] && !kr[aar_pkg::K_METER]
     && alarm_fn_cfg != '0) |=> text_view && text_index == $past(first_idx)
  ) else $error("Text view did not open on top entry");
endmodule

// *** test/aar_key_model.sv ***
`timescale 1ns/1ps
module aar_key_model (
  input  wire logic       clock,
  output logic      [6:0] key_pins,
  output logic      [3:0] alarm_active
);
  initial begin
    key_pins     = 7'h00;
    alarm_active = 4'h0;
  end
  // Extra cycles after release cover the two sync flops and edge detect
  task automatic press(input int k, input int n);
    @(negedge clock);
    key_pins[k] = 1'b1;
    repeat (n) @(negedge clock);
    key_pins[k] = 1'b0;
    repeat (5) @(negedge clock);
  endtask
  task automatic set_alarms(input logic [3:0] a);
    @(negedge clock);
    alarm_active = a;
  endtask
endmodule

// *** test/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  localparam int HOLD = 20;
  localparam int IDLE = 200;
  localparam int LONG = HOLD + 5;
  logic        clock             = 1'b0;
  logic        rst               = 1'b1;
  logic [3:0]  alarm_fn_cfg      = 4'h0;
  logic        ack_required      = 1'b0;
  logic        alarm_reset_cfg   = 1'b0;
  logic        meter_reset_right = 1'b0;
  logic        change_protect    = 1'b0;
  logic        disp_minmax       = 1'b0;
  logic        disp_counter      = 1'b0;
  logic [5:0]  seen;
  logic        seen_clr          = 1'b0;
  logic [3:0]  alarm_active;
  logic [6:0]  key_pins;
  logic [3:0]  led_on;
  logic [3:0]  alarm_withdraw;
  logic [1:0]  text_index;
  logic        text_view, text_active_sel, text_error, meter_view;
  logic        max_flash, min_flash, prompt_flash;
  logic        clear_max, clear_min, clear_meter, clear_counter;
  logic [11:0] rows [5] = '{12'hFFF, 12'hAFA, 12'hF55, 12'h632, 12'h0F0};
  int          failures    = 0;
  int          checks_done = 0;
  int          fast_n, slow_n, flips;

  aar_key_model km (.clock, .key_pins, .alarm_active);
  aar_panel #(.HOLD_CYC(HOLD), .IDLE_CYC(IDLE), .FAST_CYC(3), .SLOW_CYC(9)) dut_u (
    .clock, .rst, .alarm_active, .alarm_fn_cfg, .ack_required, .alarm_reset_cfg,
    .meter_reset_right, .change_protect, .disp_minmax, .disp_counter, .key_pins,
    .led_on, .alarm_withdraw, .text_view, .text_index, .text_active_sel, .text_error,
    .meter_view, .max_flash, .min_flash, .prompt_flash, .clear_max, .clear_min,
    .clear_meter, .clear_counter);

  initial begin
    forever #50 clock = ~clock;
  end
  // Pulses last one cycle, so latch them until the bench looks
  always @(posedge clock) begin
    seen <= (seen_clr ? 6'h00 : seen) | {|alarm_withdraw, text_error, clear_counter,
                                         clear_meter, clear_min, clear_max};
  end

  // Clear goes through the latch process so it keeps a single driver
  task automatic clr_seen();
    seen_clr = 1'b1;
    @(negedge clock);
    seen_clr = 1'b0;
  endtask

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic count_flips(input int b, input int len, output int n);
    logic prev;
    n = 0;
    prev = led_on[b];
    repeat (len) begin
      @(negedge clock);
      if (led_on[b] !== prev) n++;
      prev = led_on[b];
    end
  endtask
  task automatic report_and_stop();
    if (failures == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    report_and_stop();
  end

  initial begin
    repeat (3) @(negedge clock);
    chk("reset outputs", 8'h00, {led_on, alarm_withdraw});
    chk("reset views", 8'h00, {2'b00, text_view, meter_view, max_flash, min_flash,
        prompt_flash, text_error});
    rst = 1'b0;
    for (int i = 0; i < 5; i++) begin
      km.set_alarms(rows[i][11:8]);
      alarm_fn_cfg = rows[i][7:4];
      repeat (2) @(negedge clock);
      chk("led_on", {4'h0, rows[i][3:0]}, {4'h0, led_on});
    end
    ack_required = 1'b1;
    alarm_reset_cfg = 1'b1;
    alarm_fn_cfg = 4'hE;
    km.set_alarms(4'h4);
    count_flips(2, 36, fast_n);
    km.press(5, 1);
    chk("text entry", 8'h0D, {4'h0, text_view, text_index, text_active_sel});
    clr_seen();
    km.press(0, LONG);
    count_flips(2, 20, flips);
    chk("ack steady", 8'h01, {flips[6:0], led_on[2]});
    chk("withdraw", 8'h20, {2'b00, seen});
    km.set_alarms(4'hC);
    km.set_alarms(4'h4);
    count_flips(3, 36, slow_n);
    chk("blink rates", 8'h01, {7'h00, slow_n > 0 && fast_n > slow_n});
    km.press(3, 1);
    chk("next entry", 8'h0E, {4'h0, text_view, text_index, text_active_sel});
    km.press(0, LONG);
    count_flips(3, 20, flips);
    chk("ack slow", 8'h00, {flips[6:0], led_on[3]});
    repeat (IDLE - 70) @(negedge clock);
    chk("text open", 8'h01, {7'h00, text_view});
    repeat (60) @(negedge clock);
    chk("text closed", 8'h00, {7'h00, text_view});
    alarm_fn_cfg = 4'h0;
    clr_seen();
    km.press(5, 1);
    chk("no functions", 8'h10, {1'b0, text_view, seen});
    km.press(6, 1);
    km.press(0, LONG);
    chk("no right", 8'h01, {6'h00, prompt_flash, meter_view});
    meter_reset_right = 1'b1;
    km.press(0, LONG);
    chk("meter prompt", 8'h02, {6'h00, prompt_flash, meter_view});
    clr_seen();
    km.press(1, 1);
    chk("meter clear", 8'h09, {1'b0, seen, meter_view});
    repeat (IDLE + 30) @(negedge clock);
    chk("meter closed", 8'h00, {7'h00, meter_view});
    disp_minmax = 1'b1;
    change_protect = 1'b1;
    km.press(0, LONG);
    chk("protected", 8'h00, {6'h00, max_flash, prompt_flash});
    change_protect = 1'b0;
    km.press(0, HOLD - 10);
    chk("short press", 8'h00, {6'h00, max_flash, prompt_flash});
    clr_seen();
    km.press(0, LONG);
    chk("max step", 8'h03, {6'h00, max_flash, prompt_flash});
    km.press(1, 1);
    chk("max ok", 8'h05, {4'h0, seen[1:0], max_flash, min_flash});
    km.press(2, 1);
    chk("min abort", 8'h04, {4'h0, seen[1:0], max_flash, min_flash});
    clr_seen();
    km.press(0, LONG);
    km.press(3, 1);
    chk("max skip", 8'h01, {4'h0, seen[1:0], max_flash, min_flash});
    km.press(1, 1);
    chk("min ok", 8'h08, {4'h0, seen[1:0], max_flash, min_flash});
    clr_seen();
    km.press(0, LONG);
    km.press(2, 1);
    chk("max abort", 8'h00, {4'h0, seen[1:0], max_flash, min_flash});
    disp_minmax = 1'b0;
    disp_counter = 1'b1;
    km.press(0, LONG);
    chk("counter prompt", 8'h01, {1'b0, seen, prompt_flash});
    km.press(1, 1);
    chk("counter clear", 8'h10, {1'b0, seen, prompt_flash});
    report_and_stop();
  end
endmodule
